// *** src/serial_gain_word_loader.sv ***
module serial_gain_word_loader
  import gain_loader_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic serial_clk,
  input wire logic load_enable_n,
  input wire logic serial_gain_in,
  input wire logic forward_mode_n_sel,
  output gain_setting_t gain,
  output mode_ctl_t mode,
  output logic loading,
  output logic gain_update,
  output logic [`GL_LOADS_W-1:0] load_total
);

  ////////////////////////////////////////////////////////////////////////////
  // Gain decode

  function automatic gain_setting_t decode(input word_t code);
    gain_setting_t g;
    gain_val_t drop;
    g = '0;
    g.code = code;
    if (code > `GL_MAX_LEVEL) begin
      g.level = `GL_MAX_LEVEL;
      g.saturated = 1'b1;
    end else begin
      g.level = code;
      g.saturated = 1'b0;
    end
    g.atten = `GL_MAX_LEVEL - g.level;
    // Product stays below the gain width, so no bits are lost here
    drop = gain_val_t'(g.atten) * `GL_GAIN_STEP;
    g.gain = `GL_GAIN_MAX - drop;
    return g;
  endfunction : decode

  localparam gain_setting_t GAIN_RST = decode(`GL_RESET_CODE);

  localparam sys_state_t ST_RST = '{
    s1: `GL_PINS_IDLE,
    s2: `GL_PINS_IDLE,
    en_s3: 1'b1,
    gain: GAIN_RST,
    mode: '{pa_en: 1'b1, rev_en: 1'b0},
    loading: 1'b0,
    update: 1'b0,
    loads: '0
  };

  ////////////////////////////////////////////////////////////////////////////
  // Serial-clock side

  word_t shift_word;

  gain_shift_stage u_shift (
    .serial_clk(serial_clk),
    .rstn(rstn),
    .load_enable_n(load_enable_n),
    .serial_gain_in(serial_gain_in),
    .shift_word(shift_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // System-clock side

  sys_state_t st_q;
  sys_state_t st_d;
  logic en_rise;
  logic en_fall;

  // Edges seen after the second synchroniser stage only
  assign en_rise = st_q.s2[`GL_PIN_EN] & ~st_q.en_s3;
  assign en_fall = ~st_q.s2[`GL_PIN_EN] & st_q.en_s3;

  always_comb begin
    st_d = st_q;
    st_d.s1[`GL_PIN_EN] = load_enable_n;
    st_d.s1[`GL_PIN_FWD] = forward_mode_n_sel;
    st_d.s2 = st_q.s1;
    st_d.en_s3 = st_q.s2[`GL_PIN_EN];
    st_d.update = 1'b0;

    if (en_fall) begin
      st_d.loading = 1'b1;
    end

    // The shift word is still while the enable is high, so it is taken
    // here without a handshake; the host must not restart at once
    if (en_rise) begin
      st_d.gain = decode(shift_word);
      st_d.update = 1'b1;
      st_d.loading = 1'b0;
      st_d.loads = st_q.loads + `GL_LOADS_ONE;
    end
    // Otherwise the latch keeps the previous word

    // Both paths never on together, even for one cycle
    st_d.mode.pa_en = st_q.s2[`GL_PIN_FWD];
    st_d.mode.rev_en = ~st_q.s2[`GL_PIN_FWD];
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign gain = st_q.gain;
  assign mode = st_q.mode;
  assign loading = st_q.loading;
  assign gain_update = st_q.update;
  assign load_total = st_q.loads;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  load_start_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $fell(st_q.s2[`GL_PIN_EN]) |=> loading && !gain_update)
    else $error("Enable fall did not start a load");

  gain_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !st_q.s2[`GL_PIN_EN] |=> $stable(gain) && !gain_update)
    else $error("Gain moved while the enable was low");

  word_latch_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $rose(st_q.s2[`GL_PIN_EN]) |=> gain.code == $past(shift_word) && gain_update
      ##1 !gain_update)
    else $error("Enable rise did not latch the shift word");

  load_count_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    gain_update |-> load_total == $past(load_total) + `GL_LOADS_ONE)
    else $error("Load counter out of step with updates");

  linear_step_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    gain.code <= `GL_MAX_LEVEL |->
      gain.level == gain.code && !gain.saturated &&
      gain.gain == `GL_GAIN_MAX - gain_val_t'(`GL_MAX_LEVEL - gain.code) * `GL_GAIN_STEP)
    else $error("Linear gain decode wrong");

  saturate_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    gain.code > `GL_MAX_LEVEL |->
      gain.level == `GL_MAX_LEVEL && gain.saturated && gain.gain == `GL_GAIN_MAX)
    else $error("Gain did not saturate");

  forward_mode_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    st_q.s2[`GL_PIN_FWD] |=> mode.pa_en && !mode.rev_en)
    else $error("Forward mode not selected");

  reverse_mode_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !st_q.s2[`GL_PIN_FWD] |=> !mode.pa_en && mode.rev_en)
    else $error("Reverse path not selected");

  reset_code_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    load_total == '0 |-> gain.code == `GL_RESET_CODE && gain.atten == `GL_MAX_LEVEL)
    else $error("Gain left reset value before any load");

  ////////////////////////////////////////////////////////////////////////////
  // Status and mode consistency

  paths_exclusive_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    mode.rev_en
    |-> !mode.pa_en)
    else $error("Both amplifier paths enabled");

  path_present_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    !mode.rev_en
    |-> mode.pa_en)
    else $error("No amplifier path enabled");

  update_pulse_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    gain_update
    |=> !gain_update)
    else $error("Update pulse longer than one cycle");

  update_cause_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    gain_update
    |-> $past(en_rise))
    else $error("Update without an enable rise");

  latch_ends_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    gain_update
    |-> !loading)
    else $error("Load still open at the update");

  gain_steady_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    !gain_update
    |-> $stable(gain))
    else $error("Gain changed without an update");

  count_steady_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    !gain_update
    |-> $stable(load_total))
    else $error("Load count changed without an update");

  load_begin_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    $rose(loading)
    |-> $past(en_fall))
    else $error("Load opened without an enable fall");

  load_end_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    $fell(loading)
    |-> gain_update)
    else $error("Load closed without a latch");

  loading_quiet_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    loading
    |-> !gain_update)
    else $error("Update while a load is open");

  sat_flag_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    gain.saturated ==
      (gain.code > `GL_MAX_LEVEL))
    else $error("Saturation flag disagrees with code");

  level_sum_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    gain.level + gain.atten ==
      `GL_MAX_LEVEL)
    else $error("Level and attenuation do not add up");

  level_cap_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    gain.level <=
      `GL_MAX_LEVEL)
    else $error("Level above the maximum step");

  sync_chain_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    st_q.en_s3 ==
      $past(st_q.s2[`GL_PIN_EN]))
    else $error("Enable edge stage out of step");

  mode_cause_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    $changed(mode)
    |-> $past(st_q.s2[`GL_PIN_FWD]) != $past(st_q.s2[`GL_PIN_FWD], 2))
    else $error("Mode changed without a pin change");

  first_level_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    load_total == '0
    |-> !gain.saturated && gain.level == `GL_RESET_CODE)
    else $error("Level left minimum before any load");

  min_gain_a: assert property (
    @(posedge clk_sys)
    disable iff (!rstn)
    gain.code == `GL_RESET_CODE
    |-> gain.gain == GAIN_RST.gain && gain.atten == `GL_MAX_LEVEL)
    else $error("Code zero is not minimum gain");

endmodule : serial_gain_word_loader

// *** src/gain_loader_cfg.svh ***
`ifndef GAIN_LOADER_CFG_SVH
`define GAIN_LOADER_CFG_SVH

// Width of the held gain word; the word's top bit never reaches a stage
`define GL_WORD_W 7
// Highest code with its own gain step; all codes above it saturate
`define GL_MAX_LEVEL 7'h47
// Latch value from reset until the first completed load
`define GL_RESET_CODE 7'h00
// Gain in units of 0.1 millidecibel, two's complement
`define GL_GAIN_W 21
`define GL_GAIN_MAX 21'h3_f7a0
`define GL_GAIN_STEP 21'h1d66
// Bit positions of the synchronised pin bank
`define GL_PIN_EN 0
`define GL_PIN_FWD 1
`define GL_PINS 2
// Idle level of every synchronised pin
`define GL_PINS_IDLE 2'h3
`define GL_LOADS_W 16
`define GL_LOADS_ONE 16'h0001

`endif

// *** src/gain_loader_pkg.sv ***
`include "gain_loader_cfg.svh"

package gain_loader_pkg;

  typedef logic [`GL_WORD_W-1:0] word_t;
  typedef logic [`GL_GAIN_W-1:0] gain_val_t;

  // Decoded gain setting as seen by the attenuator core
  typedef struct packed {
    word_t code;
    word_t level;
    word_t atten;
    gain_val_t gain;
    logic saturated;
  } gain_setting_t;

  // Amplifier path selection
  typedef struct packed {
    logic pa_en;
    logic rev_en;
  } mode_ctl_t;

  typedef struct packed {
    logic [`GL_PINS-1:0] s1;
    logic [`GL_PINS-1:0] s2;
    logic en_s3;
    gain_setting_t gain;
    mode_ctl_t mode;
    logic loading;
    logic update;
    logic [`GL_LOADS_W-1:0] loads;
  } sys_state_t;

endpackage : gain_loader_pkg

// *** src/gain_shift_stage.sv ***
module gain_shift_stage
  import gain_loader_pkg::*;
(
  input wire logic serial_clk,
  input wire logic rstn,
  input wire logic load_enable_n,
  input wire logic serial_gain_in,
  output word_t shift_word
);

  word_t master_q;
  word_t master_d;
  word_t slave_q;

  ////////////////////////////////////////////////////////////////////////////
  // Master half: rising edge, only while the enable is low
  always_comb begin
    master_d = master_q;
    if (!load_enable_n) begin
      master_d = {slave_q[`GL_WORD_W-2:0], serial_gain_in};
    end
  end

  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      master_q <= `GL_RESET_CODE;
    end else begin
      master_q <= master_d;
    end
  end

  // Slave half: falling edge copies the master
  always_ff @(negedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      slave_q <= `GL_RESET_CODE;
    end else begin
      slave_q <= master_q;
    end
  end

  assign shift_word = slave_q;

  ////////////////////////////////////////////////////////////////////////////
  shift_in_a: assert property (
    @(posedge serial_clk) disable iff (!rstn)
    !load_enable_n |=> master_q == {$past(slave_q[`GL_WORD_W-2:0]), $past(serial_gain_in)})
    else $error("Shift stage did not take the serial bit");

  clock_gate_a: assert property (
    @(posedge serial_clk) disable iff (!rstn)
    load_enable_n |=> $stable(master_q))
    else $error("Shift stage moved while the enable was high");

  slave_copy_a: assert property (
    @(posedge serial_clk) disable iff (!rstn)
    $past(rstn) |-> slave_q == master_q)
    else $error("Slave half does not follow the master");

  top_drop_a: assert property (
    @(posedge serial_clk) disable iff (!rstn)
    !load_enable_n ##1 !load_enable_n |-> master_q[`GL_WORD_W-1] == $past(slave_q[`GL_WORD_W-2]))
    else $error("Oldest bit was not pushed out");

endmodule : gain_shift_stage

// *** test/gain_host.sv ***
////////////////////////////////////////////////////////////////////////////////
// Host side of the three-wire gain link
module gain_host (
  output logic sclk,
  output logic en_n,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b0;
    en_n = 1'b1;
    sdi = 1'b0;
  end

  // Link clock also pulses outside frames in stray; odd offset keeps frame clocks off the system edges
  task automatic frame(input logic [7:0] w, input int n);
    #5 en_n = 1'b0;
    #24;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    // Released line must not look like held data
    sdi = ~sdi;
  endtask : frame

  task automatic finish_load();
    #24 en_n = 1'b1;
  endtask : finish_load

  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      sdi = ~sdi;
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask : stray
endmodule : gain_host

// *** test/tb.sv ***
`include "gain_loader_cfg.svh"

module tb;
  import gain_loader_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic fwd_n = 1'b1;
  logic sclk, en_n, sdi, loading, gain_update;
  gain_setting_t gain;
  mode_ctl_t mode;
  logic [`GL_LOADS_W-1:0] load_total;
  int failures = 0;
  int n_checks = 0;
  int sr = 0;
  int loads = 0;
  logic [7:0] lfsr = 8'h52;
  logic [7:0] codes [8] = '{8'h00, 8'h47, 8'h48, 8'h7f, 8'h80, 8'hc7, 8'hff, 8'h2a};

  always #4 clk_sys = ~clk_sys;

  gain_host i_host (.sclk(sclk), .en_n(en_n), .sdi(sdi));

  serial_gain_word_loader i_dut (.clk_sys(clk_sys), .rstn(rstn), .serial_clk(sclk),
    .load_enable_n(en_n), .serial_gain_in(sdi), .forward_mode_n_sel(fwd_n), .gain(gain),
    .mode(mode), .loading(loading), .gain_update(gain_update), .load_total(load_total));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : next_rand

  task automatic report(input string msg);
    failures++;
    $display("CHECK FAILED %0t %s", $time, msg);
  endtask : report

  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic check_gain();
    gain_setting_t e;
    int lvl;
    lvl = (sr > 71) ? 71 : sr;
    e.code = sr[6:0];
    e.level = lvl[6:0];
    e.atten = 7'(71 - lvl);
    e.gain = 21'(260000 - (71 - lvl) * 7526);
    e.saturated = (sr > 71);
    n_checks++;
    if (gain !== e) report("gain setting");
  endtask : check_gain

  task automatic check_mode(input logic fwd);
    n_checks++;
    if (mode !== {fwd, ~fwd}) report("amplifier mode");
  endtask : check_mode

  task automatic check_loading(input logic exp);
    n_checks++;
    if (loading !== exp) report("loading flag");
  endtask : check_loading

  task automatic check_total();
    n_checks++;
    if (load_total !== 16'(loads)) report("load count");
  endtask : check_total

  ////////////////////////////////////////////////////////////////////////////////
  task automatic load(input logic [7:0] w, input int n);
    int t;
    i_host.frame(w, n);
    check_gain();
    check_loading(1'b1);
    // Model shift register: only the last seven bits survive
    for (int i = n - 1; i >= 0; i--) sr = ((sr << 1) | w[i]) & 127;
    i_host.finish_load();
    loads++;
    for (t = 0; t < 40 && gain_update !== 1'b1; t++) @(negedge clk_sys);
    if (t == 40) begin
      report("no gain update");
      tally_and_finish();
    end
    check_gain();
    check_total();
    check_loading(1'b0);
    repeat (3) @(negedge clk_sys);
  endtask : load

  initial begin
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    check_gain();
    check_mode(1'b1);
    foreach (codes[i]) load(codes[i], 8);
    load(8'h05, 3);
    i_host.stray(5);
    load(8'h00, 0);
    for (int i = 0; i < 12; i++) begin
      lfsr = next_rand(lfsr);
      fwd_n = lfsr[0];
      load(lfsr, 8);
      check_mode(lfsr[0]);
    end
    tally_and_finish();
  end
endmodule : tb
